//--- logic/crcfg_top.sv
// receive configuration registers with axi4-lite slave and receive path steering
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module crcfg_top (
  input  wire logic        aclk,            // 200 MHz clock
  input  wire logic        aresetn,         // sync reset, low active
  input  wire logic [7:0]  awaddr,          // write address
  input  wire logic        awvalid,         // write address valid
  output logic             awready,         // write address ready
  input  wire logic [31:0] wdata,           // write data
  input  wire logic [3:0]  wstrb,           // write strobes
  input  wire logic        wvalid,          // write data valid
  output logic             wready,          // write data ready
  output logic [1:0]       bresp,           // write response
  output logic             bvalid,          // write response valid
  input  wire logic        bready,          // write response ready
  input  wire logic [7:0]  araddr,          // read address
  input  wire logic        arvalid,         // read address valid
  output logic             arready,         // read address ready
  output logic [31:0]      rdata,           // read data
  output logic [1:0]       rresp,           // read response
  output logic             rvalid,          // read data valid
  input  wire logic        rready,          // read data ready
  input  wire logic        aux_serial_in_pin, // auxiliary serial input
  input  wire logic        analog_demod,    // analog demodulator output
  input  wire logic        speed_above_106, // link faster than 106 kBd
  input  wire logic        tx_done,         // pulse, transmission finished
  input  wire logic        cmd_is_rx,       // plain receive command
  input  wire logic        rf_field_on,     // external field present
  input  wire logic        bit_tick,        // bit-clock pulse
  input  wire logic [3:0]  sig_strength,    // decoder input strength
  input  wire logic [3:0]  weak_half,       // weaker half-bit amplitude
  input  wire logic [3:0]  strong_half,     // stronger half-bit amplitude
  input  wire logic [3:0]  i_amp,           // i-channel amplitude
  input  wire logic [3:0]  q_amp,           // q-channel amplitude
  input  wire logic        i_data,          // i-channel data
  input  wire logic        q_data,          // q-channel data
  input  wire logic        comm_active,     // communication in progress
  input  wire logic        receiving,       // data reception phase
  input  wire logic        carrier_tick,    // 13.56 MHz enable pulse
  input  wire logic [11:0] timer_prescale_value, // prescaler setting
  output logic             rx_serial,       // framer input stream
  output logic             rx_enable,       // receiver active
  output logic             decode_enable,   // strength high enough
  output logic             bit_collision,   // collision detected
  output logic             q_selected,      // q channel in use
  output logic             rx_channel_data, // selected channel data
  output logic             timer_tick,      // timer prescaler tick
  output logic [1:0]       pll_tau,         // pll time constant
  output logic             pll_freeze,      // pll frozen
  output logic [3:0]       extra_response_time // bit periods added
);
  typedef struct packed {
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       aw_held;
    logic       w_held;
    logic       w_lane0;
    logic [7:0] waddr;
    logic [7:0] wbyte;
    logic       arready;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rbyte;
    logic [7:0] src_sel;
    logic [7:0] thresh;
    logic [7:0] demod;
    logic [7:0] card_tx;
    logic       rx_serial;
    logic       decode_enable;
    logic       bit_collision;
    logic       q_selected;
    logic       frozen_q;
    logic       comm_prev;
    logic       rx_channel_data;
    logic [1:0] pll_tau;
    logic       pll_freeze;
    logic [3:0] extra_resp;
  } crcfg_st_t;
  crcfg_st_t s, next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // field views
  logic [1:0] input_sel;
  logic [5:0] guard_delay;
  logic [3:0] decode_min_strength;
  logic [2:0] collision_threshold;
  logic [1:0] channel_combine_mode;
  logic       channel_fix;
  logic       timer_divider_even;
  logic [1:0] pll_receive_tau;
  logic [1:0] pll_burst_tau;
  logic [1:0] tx_wait;
  logic       src_bit;
  logic       stronger_q;
  logic [6:0] weak_scaled;
  logic [6:0] strong_scaled;
  // fields sit in live registers
  assign input_sel            = s.src_sel[7:6];
  assign guard_delay          = s.src_sel[5:0];
  assign decode_min_strength  = s.thresh[7:4];
  assign collision_threshold  = s.thresh[2:0];
  assign channel_combine_mode = s.demod[7:6];
  assign channel_fix          = s.demod[5];
  assign timer_divider_even   = s.demod[4];
  assign pll_receive_tau      = s.demod[3:2];
  assign pll_burst_tau        = s.demod[1:0];
  assign tx_wait              = s.card_tx[1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // next state: bus slave, then receive steering
  always_comb
  begin
    next_s = s;
    src_bit = 1'b0;
    stronger_q = (q_amp > i_amp);
    // weak*8 against strong*level keeps the ratio exact without a divider
    weak_scaled = {weak_half, 3'h0};
    strong_scaled = 7'(strong_half * collision_threshold);
    // write address and data taken in either order
    if (s.awready && awvalid)
    begin
      next_s.aw_held = 1'b1;
      next_s.waddr = awaddr;
    end
    if (s.wready && wvalid)
    begin
      next_s.w_held = 1'b1;
      next_s.wbyte = wdata[7:0];
      next_s.w_lane0 = wstrb[0];
    end
    if (s.bvalid && bready)
      next_s.bvalid = 1'b0;
    if (next_s.aw_held && next_s.w_held && !s.bvalid)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = crcfg_pkg::RESP_OKAY;
      // reserved bits keep reset value on every write
      if (next_s.waddr == crcfg_pkg::ADDR_SRC_SEL)
      begin
        if (next_s.w_lane0)
          next_s.src_sel = next_s.wbyte;
      end
      else if (next_s.waddr == crcfg_pkg::ADDR_THRESH)
      begin
        if (next_s.w_lane0)
          next_s.thresh = (next_s.wbyte & crcfg_pkg::WMASK_THRESH)
                        | (crcfg_pkg::RST_THRESH & ~crcfg_pkg::WMASK_THRESH);
      end
      else if (next_s.waddr == crcfg_pkg::ADDR_DEMOD)
      begin
        if (next_s.w_lane0)
          next_s.demod = next_s.wbyte;
      end
      else if (next_s.waddr == crcfg_pkg::ADDR_CARD_TX)
      begin
        if (next_s.w_lane0)
          next_s.card_tx = (next_s.wbyte & crcfg_pkg::WMASK_CARD_TX)
                         | (crcfg_pkg::RST_CARD_TX & ~crcfg_pkg::WMASK_CARD_TX);
      end
      else if (next_s.waddr == crcfg_pkg::ADDR_RSVD_A || next_s.waddr == crcfg_pkg::ADDR_RSVD_B)
        next_s.bresp = crcfg_pkg::RESP_OKAY;
      else
        next_s.bresp = crcfg_pkg::RESP_SLVERR;
    end
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;
    // read channel
    if (s.rvalid && rready)
      next_s.rvalid = 1'b0;
    if (s.arready && arvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = crcfg_pkg::RESP_OKAY;
      if (araddr == crcfg_pkg::ADDR_SRC_SEL)
        next_s.rbyte = s.src_sel;
      else if (araddr == crcfg_pkg::ADDR_THRESH)
        next_s.rbyte = s.thresh;
      else if (araddr == crcfg_pkg::ADDR_DEMOD)
        next_s.rbyte = s.demod;
      else if (araddr == crcfg_pkg::ADDR_CARD_TX)
        next_s.rbyte = s.card_tx;
      else if (araddr == crcfg_pkg::ADDR_RSVD_A || araddr == crcfg_pkg::ADDR_RSVD_B)
        next_s.rbyte = crcfg_pkg::RST_RSVD;
      else
      begin
        next_s.rbyte = 8'h00;
        next_s.rresp = crcfg_pkg::RESP_SLVERR;
      end
    end
    next_s.arready = !next_s.rvalid;
    // input source for the framer
    case (input_sel)
      crcfg_pkg::SEL_LOW:     src_bit = 1'b0;
      crcfg_pkg::SEL_AUX_MC:  src_bit = aux_serial_in_pin;
      crcfg_pkg::SEL_ANALOG:  src_bit = analog_demod;
      default:                src_bit = speed_above_106 && aux_serial_in_pin;
    endcase
    // guard time blanks the input entirely
    next_s.rx_serial = src_bit && rx_enable;
    next_s.decode_enable = (sig_strength >= decode_min_strength);
    next_s.bit_collision = next_s.decode_enable && (weak_scaled >= strong_scaled)
                         && (collision_threshold != 3'h0);
    // channel choice; reserved codes fall back to stronger channel
    next_s.comm_prev = comm_active;
    if (comm_active && !s.comm_prev)
      next_s.frozen_q = stronger_q;
    if (channel_fix)
      next_s.q_selected = channel_combine_mode[0];
    else if (channel_combine_mode == crcfg_pkg::COMB_FREEZE && comm_active)
      next_s.q_selected = next_s.frozen_q;
    else
      next_s.q_selected = stronger_q;
    next_s.rx_channel_data = next_s.q_selected ? q_data : i_data;
    // pll constant follows the phase
    next_s.pll_tau = receiving ? pll_receive_tau : pll_burst_tau;
    next_s.pll_freeze = receiving && (pll_receive_tau == crcfg_pkg::TAU_FROZEN);
    next_s.extra_resp = {2'h0, tx_wait} + crcfg_pkg::RESP_EXTRA;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.src_sel <= crcfg_pkg::RST_SRC_SEL;
      s.thresh  <= crcfg_pkg::RST_THRESH;
      s.demod   <= crcfg_pkg::RST_DEMOD;
      s.card_tx <= crcfg_pkg::RST_CARD_TX;
      s.extra_resp <= crcfg_pkg::RESP_EXTRA;
    end
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // guard timer and prescaler
  crcfg_guard u_guard (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .guard_delay (guard_delay),
    .tx_done     (tx_done),
    .cmd_is_rx   (cmd_is_rx),
    .rf_field_on (rf_field_on),
    .bit_tick    (bit_tick),
    .rx_enable   (rx_enable)
  );
  crcfg_presc u_presc (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .carrier_tick (carrier_tick),
    .prescale     (timer_prescale_value),
    .div_even     (timer_divider_even),
    .timer_tick   (timer_tick)
  );

  // outputs straight from flops
  assign awready = s.awready;
  assign wready  = s.wready;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign arready = s.arready;
  assign rvalid  = s.rvalid;
  assign rresp   = s.rresp;
  assign rdata   = {24'h000000, s.rbyte};
  assign rx_serial       = s.rx_serial;
  assign decode_enable   = s.decode_enable;
  assign bit_collision   = s.bit_collision;
  assign q_selected      = s.q_selected;
  assign rx_channel_data = s.rx_channel_data;
  assign pll_tau         = s.pll_tau;
  assign pll_freeze      = s.pll_freeze;
  assign extra_response_time = s.extra_resp;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_sel_low;
    (input_sel == crcfg_pkg::SEL_LOW) |=> !rx_serial;
  endproperty
  a_sel_low: assert property (p_sel_low) else $error("low source not low");
  property p_nrz;
    (input_sel == crcfg_pkg::SEL_AUX_NRZ && speed_above_106 && rx_enable)
      |=> (rx_serial == $past(aux_serial_in_pin));
  endproperty
  a_nrz: assert property (p_nrz) else $error("nrz path wrong");
  property p_min_level;
    (sig_strength < decode_min_strength) |=> !decode_enable && !bit_collision;
  endproperty
  a_min_level: assert property (p_min_level) else $error("weak signal decoded");
  property p_fix_i;
    (channel_fix && !channel_combine_mode[0]) |=> !q_selected && (rx_channel_data == $past(i_data));
  endproperty
  a_fix_i: assert property (p_fix_i) else $error("fixed i not used");
  sequence s_rsvd_read;
    arready && arvalid && (araddr == crcfg_pkg::ADDR_RSVD_A);
  endsequence
  property p_rsvd_read;
    s_rsvd_read |=> rvalid && (rdata == 32'h00000000) && (rresp == crcfg_pkg::RESP_OKAY);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved slot not zero");
  property p_rsvd_bits;
    (s.thresh[3] == 1'b0) && (s.card_tx[7:2] == crcfg_pkg::RST_CARD_TX[7:2]);
  endproperty
  a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved bit changed");
  property p_freeze;
    (receiving && pll_receive_tau == crcfg_pkg::TAU_FROZEN) |=> pll_freeze;
  endproperty
  a_freeze: assert property (p_freeze) else $error("pll not frozen");
  // unfixed code 00 tracks the stronger channel, code 01 latches it at start
  property p_strong;
    (!channel_fix && channel_combine_mode == crcfg_pkg::COMB_STRONG)
      |=> (q_selected == $past(stronger_q));
  endproperty
  a_strong: assert property (p_strong) else $error("stronger channel not chosen");
  sequence s_comm_start;
    comm_active && !s.comm_prev && !channel_fix
      && (channel_combine_mode == crcfg_pkg::COMB_FREEZE);
  endsequence
  property p_freeze_pick;
    s_comm_start |=> (q_selected == $past(stronger_q));
  endproperty
  a_freeze_pick: assert property (p_freeze_pick) else $error("start channel wrong");
  property p_freeze_hold;
    (comm_active && s.comm_prev && !channel_fix
      && channel_combine_mode == crcfg_pkg::COMB_FREEZE) |=> (q_selected == $past(s.frozen_q));
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("frozen channel moved");
  property p_fix_q;
    (channel_fix && channel_combine_mode[0])
      |=> q_selected && (rx_channel_data == $past(q_data));
  endproperty
  a_fix_q: assert property (p_fix_q) else $error("fixed q not used");
  property p_decode;
    (sig_strength >= decode_min_strength) |=> decode_enable;
  endproperty
  a_decode: assert property (p_decode) else $error("strong signal not decoded");
  property p_burst_tau;
    !receiving |=> (pll_tau == $past(pll_burst_tau)) && !pll_freeze;
  endproperty
  a_burst_tau: assert property (p_burst_tau) else $error("burst tau not used");
endmodule

//--- logic/crcfg_pkg.sv
// package with register map, field layout and encodings of the receive configuration block
// Notes on behaviour
// - input select 00 gives low, 01 aux Manchester, 10 analog demodulator (default).
// - input select 11 takes aux NRZ data, valid only above 106 kBd.
// - after transmit, receiver stays off for guard delay bit-clocks, input ignored.
// - plain receive skips the guard delay; every other command applies it.
// - guard counter also starts when the external RF field comes on.
// - decoder evaluates only signals reaching the minimum strength setting.
// - collision flagged only when weaker half-bit reaches threshold relative to stronger.
// - without fixing, 00 picks stronger channel, 01 picks and freezes; 10/11 reserved.
// - with fixing, combine low bit 0 selects I, 1 selects Q.
// - even bit clear: timer tick is carrier over two times prescale plus one.
// - even bit set: timer tick is carrier over two times prescale plus two.
// - receive PLL tau applies during reception; 00 freezes the PLL.
// - separate burst PLL tau applies outside reception.
// - slots 1Ah and 1Bh have no function, reset 00h, all reserved.
// - card transmit register at 1Ch holds two-bit wait field, resets 62h.
// - source select and threshold reset 84h, demodulator setup resets 4Dh.
// - extra response time is the wait field plus seven bit periods.
package crcfg_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SRC_SEL = 8'h17;
  localparam logic [7:0] IDX_THRESH  = 8'h18;
  localparam logic [7:0] IDX_DEMOD   = 8'h19;
  localparam logic [7:0] IDX_RSVD_A  = 8'h1a;
  localparam logic [7:0] IDX_RSVD_B  = 8'h1b;
  localparam logic [7:0] IDX_CARD_TX = 8'h1c;
  localparam logic [7:0] ADDR_SRC_SEL = IDX_SRC_SEL << 2;
  localparam logic [7:0] ADDR_THRESH  = IDX_THRESH << 2;
  localparam logic [7:0] ADDR_DEMOD   = IDX_DEMOD << 2;
  localparam logic [7:0] ADDR_RSVD_A  = IDX_RSVD_A << 2;
  localparam logic [7:0] ADDR_RSVD_B  = IDX_RSVD_B << 2;
  localparam logic [7:0] ADDR_CARD_TX = IDX_CARD_TX << 2;
  // reset values
  localparam logic [7:0] RST_SRC_SEL = 8'h84;
  localparam logic [7:0] RST_THRESH  = 8'h84;
  localparam logic [7:0] RST_DEMOD   = 8'h4d;
  localparam logic [7:0] RST_RSVD    = 8'h00;
  localparam logic [7:0] RST_CARD_TX = 8'h62;
  // writable bit masks; other bits are reserved
  localparam logic [7:0] WMASK_SRC_SEL = 8'hff;
  localparam logic [7:0] WMASK_THRESH  = 8'hf7;
  localparam logic [7:0] WMASK_DEMOD   = 8'hff;
  localparam logic [7:0] WMASK_CARD_TX = 8'h03;
  // input selector codes
  localparam logic [1:0] SEL_LOW    = 2'h0;
  localparam logic [1:0] SEL_AUX_MC = 2'h1;
  localparam logic [1:0] SEL_ANALOG = 2'h2;
  localparam logic [1:0] SEL_AUX_NRZ = 2'h3;
  // channel combine codes and misc
  localparam logic [1:0] COMB_STRONG  = 2'h0;
  localparam logic [1:0] COMB_FREEZE  = 2'h1;
  localparam logic [1:0] TAU_FROZEN   = 2'h0;
  localparam logic [3:0] RESP_EXTRA   = 4'h7;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  // guard state machine
  typedef enum logic [1:0] {
    GRD_OPEN  = 2'b01,
    GRD_WAIT  = 2'b10
  } crcfg_guard_t;
endpackage

//--- logic/crcfg_guard.sv
// receiver guard delay timer after transmission and field switch-on
`timescale 1ns/1ps
module crcfg_guard (
  input  wire logic       aclk,         // system clock
  input  wire logic       aresetn,      // sync reset, low active
  input  wire logic [5:0] guard_delay,  // receive_guard_delay field
  input  wire logic       tx_done,      // pulse, transmission finished
  input  wire logic       cmd_is_rx,    // plain receive command active
  input  wire logic       rf_field_on,  // external rf field present
  input  wire logic       bit_tick,     // one bit-clock pulse
  output logic            rx_enable     // receiver active
);
  typedef struct packed {
    crcfg_pkg::crcfg_guard_t st;
    logic [5:0]              cnt;
    logic                    rf_prev;
    logic                    rx_enable;
  } crcfg_gst_t;
  crcfg_gst_t s, next_s;
  logic start;
  // field rise restarts too, so a freshly powered card is not sampled early
  always_comb
  begin
    next_s = s;
    next_s.rf_prev = rf_field_on;
    start = (rf_field_on && !s.rf_prev) || (tx_done && !cmd_is_rx);
    if (start)
    begin
      next_s.cnt = guard_delay;
      next_s.st = (guard_delay == 6'h00) ? crcfg_pkg::GRD_OPEN : crcfg_pkg::GRD_WAIT;
    end
    else
    begin
      case (s.st)
        crcfg_pkg::GRD_WAIT:
        begin
          if (bit_tick)
          begin
            next_s.cnt = s.cnt - 6'h01;
            if (s.cnt <= 6'h01)
              next_s.st = crcfg_pkg::GRD_OPEN;
          end
        end
        default: next_s.st = crcfg_pkg::GRD_OPEN;
      endcase
    end
    next_s.rx_enable = (next_s.st == crcfg_pkg::GRD_OPEN);
  end
  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '{st: crcfg_pkg::GRD_OPEN, cnt: 6'h00, rf_prev: 1'b0, rx_enable: 1'b1};
    else
      s <= next_s;
  end
  assign rx_enable = s.rx_enable;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_tx_start;
    tx_done && !cmd_is_rx && (guard_delay != 6'h00);
  endsequence
  property p_guard_closed;
    s_tx_start |=> !rx_enable;
  endproperty
  a_guard_closed: assert property (p_guard_closed) else $error("guard not applied");
  property p_rx_no_guard;
    (tx_done && cmd_is_rx && !(rf_field_on && !s.rf_prev) && rx_enable) |=> rx_enable;
  endproperty
  a_rx_no_guard: assert property (p_rx_no_guard) else $error("receive used guard");
  property p_rf_start;
    (rf_field_on && !s.rf_prev && guard_delay != 6'h00) |=> !rx_enable;
  endproperty
  a_rf_start: assert property (p_rf_start) else $error("field rise no guard");
endmodule

//--- logic/crcfg_presc.sv
// timer prescaler with odd or even divide
`timescale 1ns/1ps
module crcfg_presc (
  input  wire logic        aclk,          // system clock
  input  wire logic        aresetn,       // sync reset, low active
  input  wire logic        carrier_tick,  // 13.56 MHz enable pulse
  input  wire logic [11:0] prescale,      // timer_prescale_value
  input  wire logic        div_even,      // timer_divider_even
  output logic             timer_tick     // one pulse per period
);
  typedef struct packed {
    logic [12:0] cnt;
    logic        tick;
  } crcfg_pst_t;
  crcfg_pst_t s, next_s;
  logic [12:0] limit;
  // period is limit+1 carrier ticks
  always_comb
  begin
    next_s = s;
    limit = {prescale, 1'b0} + {12'h000, div_even};
    next_s.tick = 1'b0;
    if (carrier_tick)
    begin
      if (s.cnt >= limit)
      begin
        next_s.cnt = 13'h0000;
        next_s.tick = 1'b1;
      end
      else
        next_s.cnt = s.cnt + 13'h0001;
    end
  end
  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end
  assign timer_tick = s.tick;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_tick_end;
    (carrier_tick && s.cnt == ({prescale, 1'b0} + {12'h000, div_even})) |=> timer_tick;
  endproperty
  a_tick_end: assert property (p_tick_end) else $error("tick missed");
  property p_no_early;
    (carrier_tick && s.cnt < ({prescale, 1'b0} + {12'h000, div_even})) |=> !timer_tick;
  endproperty
  a_no_early: assert property (p_no_early) else $error("early tick");
endmodule

//--- testbench/crcfg_top_tb.sv
// self-checking bench for the receive configuration block over axi4-lite
`timescale 1ns/1ps
module crcfg_top_tb;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'hf, extra_response_time;
  logic        awready, wready, bvalid, arready, rvalid, rx_serial, rx_enable;
  logic        decode_enable, bit_collision, q_selected, rx_channel_data, timer_tick, pll_freeze;
  logic [1:0]  bresp, rresp, pll_tau, r;
  logic        aux_serial_in_pin = 1'b0, analog_demod = 1'b0, speed_above_106 = 1'b1;
  logic        tx_done = 1'b0, cmd_is_rx = 1'b0, rf_field_on = 1'b0, bit_tick = 1'b0;
  logic        i_data = 1'b0, q_data = 1'b1, comm_active = 1'b0, receiving = 1'b0;
  logic        carrier_tick = 1'b1;
  logic [3:0]  sig_strength = 4'h0, weak_half = 4'h0, strong_half = 4'h8;
  logic [3:0]  i_amp = 4'h3, q_amp = 4'h5;
  logic [11:0] timer_prescale_value = 12'h002;
  int          error_cnt = 0, comparisons = 0, n;
  // table order: source select, threshold, demodulator, two reserved slots, card transmit
  logic [7:0]  rst_v [6] = '{8'h84, 8'h84, 8'h4d, 8'h00, 8'h00, 8'h62};
  logic [7:0]  msk_v [6] = '{8'hff, 8'hf7, 8'hff, 8'h00, 8'h00, 8'h03};
  localparam logic [7:0] SRC = crcfg_pkg::ADDR_SRC_SEL;
  localparam logic [7:0] DEM = crcfg_pkg::ADDR_DEMOD;

  crcfg_top dut (.*);

  always #2.5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  // bus and compare tasks
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // address and data released separately, whichever is taken first
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bit ad, dd;
    ad = 0;
    dd = 0;
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge aclk);
      if (awready === 1'b1 && !ad) begin awvalid <= 1'b0; ad = 1; end
      if (wready === 1'b1 && !dd) begin wvalid <= 1'b0; dd = 1; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // two bit-clocks: receiver must stay off after the first, return after the second
  task automatic guard_seq();
    cyc(2);
    chk("rx_enable", 0, rx_enable);
    for (int t = 0; t < 2; t++)
    begin
      bit_tick <= 1'b1;
      @(posedge aclk);
      bit_tick <= 1'b0;
      cyc(2);
      chk("rx_enable", t, rx_enable);
    end
  endtask
  // period counted in clocks; carrier tick runs every clock
  task automatic tper(input int e);
    do @(posedge aclk); while (timer_tick !== 1'b1);
    n = 0;
    do begin @(posedge aclk); n++; end while (timer_tick !== 1'b1);
    chk("timer period", e, n);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the few hundred clocks the sequence needs
  initial
  begin
    cyc(20000);
    error_cnt++;
    end_of_test();
  end
  // main sequence
  initial
  begin
    cyc(3);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) begin rd(SRC + 8'(i * 4)); chk("reset", rst_v[i], d); end
    receiving <= 1'b1;
    cyc(3);
    chk("pll_tau rcv", 3, pll_tau);
    receiving <= 1'b0;
    cyc(3);
    chk("pll_tau burst", 1, pll_tau);
    for (int i = 0; i < 6; i++)
    begin
      wr(SRC + 8'(i * 4), 8'hff);
      chk("bresp", crcfg_pkg::RESP_OKAY, r);
      rd(SRC + 8'(i * 4));
      chk("masked", (msk_v[i] | rst_v[i]), d);
    end
    chk("extra time", 4'ha, extra_response_time);
    // each selector code with both input polarities, guard delay zero
    for (int c = 0; c < 4; c++)
      for (int v = 0; v < 2; v++)
      begin
        aux_serial_in_pin <= v[0];
        analog_demod <= ~v[0];
        wr(SRC, {c[1:0], 6'h00});
        cyc(3);
        chk("rx_serial", (c == 1 || c == 3) ? v : (c == 2) ? 1 - v : 0, rx_serial);
      end
    speed_above_106 <= 1'b0;
    cyc(3);
    chk("rx_serial slow nrz", 0, rx_serial);
    wr(SRC, 8'h82);
    tx_done <= 1'b1;
    @(posedge aclk);
    tx_done <= 1'b0;
    guard_seq();
    rf_field_on <= 1'b1;
    guard_seq();
    cmd_is_rx <= 1'b1;
    tx_done <= 1'b1;
    @(posedge aclk);
    tx_done <= 1'b0;
    cyc(2);
    chk("rx_enable plain rx", 1, rx_enable);
    wr(crcfg_pkg::ADDR_THRESH, 8'h84);
    for (int s = 7; s < 9; s++) begin sig_strength <= 4'(s); cyc(3); chk("decode", s - 7, decode_enable); end
    for (int w = 3; w < 5; w++) begin weak_half <= 4'(w); cyc(3); chk("collision", w - 3, bit_collision); end
    receiving <= 1'b1;
    wr(DEM, 8'h20);
    cyc(2);
    chk("fixed i", {1'b0, 1'b0, 1'b1}, {q_selected, rx_channel_data, pll_freeze});
    wr(DEM, 8'h60);
    cyc(2);
    chk("fixed q", {1'b1, 1'b1}, {q_selected, rx_channel_data});
    wr(DEM, 8'h00);
    cyc(2);
    chk("stronger q", 1, q_selected);
    i_amp <= 4'h7;
    cyc(3);
    chk("stronger i", 0, q_selected);
    tper(5);
    wr(DEM, 8'h10);
    tper(6);
    // freeze code: choice made at start of communication holds until it ends
    wr(DEM, 8'h40);
    comm_active <= 1'b1;
    cyc(3);
    i_amp <= 4'h3;
    cyc(3);
    chk("frozen i", 0, q_selected);
    comm_active <= 1'b0;
    cyc(3);
    chk("released q", 1, q_selected);
    rd(8'h00);
    chk("unmapped rresp", crcfg_pkg::RESP_SLVERR, r);
    wr(8'h00, 8'hff);
    chk("unmapped bresp", crcfg_pkg::RESP_SLVERR, r);
    end_of_test();
  end
endmodule
